// *** core/vfs_supervisor.sv ***
// Purpose : supply/clock supervision, fault monitoring, direction and position
//           feedback, neutral-band solenoid disable
// Assumes : measurement codes come from converters outside this clock domain
// Notes   : long delays are parameters so simulation can shorten them
//
// Contract
// - supply above 36 V disables solenoids
// - supply below 8.5 V disables solenoids
// - failed internal clock disables solenoids
// - supply/clock trips never raise fault
// - inactive fault output actively driven low
// - both direction flags low during fault
// - solenoid supply off: setpoint unchecked, 50 %; code forces this only with direction_flag_option set
// - position feedback 0.5-4.5 V, inverted, 2.5 V neutral
// - direction flag high at neutral, low outside
// - fall beyond 0.8 mm, rise inside 0.4 mm
// - travel toward A lowers only A flag
// - setpoint in 48-52 % band disables solenoids
// - band entry waits 750-1000 ms before disable
// - band exit reactivates within 50 ms
// - monitoring continues, loop passive in neutral
// - solenoid status high active, low passive
// - six-pin float: disable without status output
// - active mode: 500 ms error latches shutdown
// - passive mode: 250 ms error, 100 ms hold
// - setpoint outside 15-85 % is an error
// - spool beyond demand plus 12 % is error
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module vfs_supervisor
    import vfs_pkg::*;
#(
    parameter logic [31:0] ACT_DLY    = ACT_DLY_CYC,
    parameter logic [31:0] PAS_DLY    = PAS_DLY_CYC,
    parameter logic [31:0] HOLD_MIN   = HOLD_MIN_CYC,
    parameter logic [31:0] NEUT_ENTER = NEUT_ENTER_CYC,
    parameter logic [31:0] NEUT_EXIT  = NEUT_EXIT_CYC,
    parameter logic [31:0] FLASH_HALF = FLASH_HALF_CYC
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [15:0] main_supply_mv,
    input  wire logic [9:0]  control_setpoint,
    input  wire logic [15:0] spool_travel_um,
    input  wire logic        solenoid_supply_on,
    input  wire logic        clock_fail,
    input  wire logic        xdcr_fault,
    output logic             solenoid_enable,
    output logic             loop_active,
    output logic             fault_out,
    output logic             fault_out_oe,
    output logic             dir_flag_port_a,
    output logic             dir_flag_port_b,
    output logic      [15:0] position_feedback_mv,
    output logic             solenoid_status,
    output logic             led_green,
    output logic             led_red
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // converter words are assumed held for several clocks, so two flops
    // per bit are enough; a word caught mid-change settles next sample
    localparam int SYNC_W = 45;
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= {solenoid_supply_on, clock_fail, xdcr_fault,
                        main_supply_mv, control_setpoint, spool_travel_um};
            sync_ff <= meta_ff;
        end
    end

    logic               s_sol_on;
    logic               s_clk_fail;
    logic               s_xdcr;
    logic [15:0]        s_supply;
    logic [9:0]         s_sp;
    logic signed [15:0] s_travel;
    assign {s_sol_on, s_clk_fail, s_xdcr, s_supply, s_sp, s_travel} = sync_ff;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    vfs_ctrl_t   ctrl_ff;
    vfs_status_t status;
    logic [31:0] rdata_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= CTRL_RST;
        end else if (reg_wr && reg_addr == REG_CTRL_OFS) begin
            ctrl_ff <= reg_wdata[4:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd && reg_addr == REG_CTRL_OFS) begin
            rdata_ff <= {27'h0000000, ctrl_ff};
        end else if (reg_rd && reg_addr == REG_STATUS_OFS) begin
            rdata_ff <= {21'h000000, status};
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // supply and clock supervision
    // ------------------------------------------------------------------
    logic supply_trip;
    logic clock_trip;
    assign supply_trip = (s_supply > SUPPLY_HI_MV)
                       || (s_supply < SUPPLY_LO_MV);
    assign clock_trip  = s_clk_fail;

    // ------------------------------------------------------------------
    // setpoint and error detection
    // ------------------------------------------------------------------
    logic       sp_forced;
    logic [9:0] sp_eff;
    logic       sp_err;
    logic       neut_passive_ff;
    logic       sol_en_ff;

    assign sp_forced = ctrl_ff.direction_flag_option && !s_sol_on;
    assign sp_eff    = sp_forced ? SP_NEUT_PM : s_sp;
    assign sp_err    = !sp_forced
                    && (s_sp < SP_MIN_PM || s_sp > SP_MAX_PM);

    logic signed [19:0] demand_um;
    logic signed [19:0] act_um;
    logic               loop_dev;
    logic               loop_err;

    assign demand_um = (signed'({10'h000, sp_eff}) - signed'({10'h000, SP_NEUT_PM}))
                     * UM_PER_PM;
    assign act_um    = {{4{s_travel[15]}}, s_travel};

    always_comb begin
        if (demand_um == 20'sh00000) begin
            loop_dev = (act_um > NEUT_TOL_UM) || (act_um < -NEUT_TOL_UM);
        end else if (demand_um > 20'sh00000) begin
            loop_dev = (act_um > demand_um + LOOP_TOL_UM)
                    || (act_um < -NEUT_TOL_UM);
        end else begin
            loop_dev = (act_um < demand_um - LOOP_TOL_UM)
                    || (act_um > NEUT_TOL_UM);
        end
    end

    // the loop is only judged while it is actually closed
    assign loop_err = loop_dev && sol_en_ff && !neut_passive_ff;

    logic err_any;
    assign err_any = sp_err || s_xdcr || loop_err;

    // ------------------------------------------------------------------
    // fault monitoring
    // ------------------------------------------------------------------
    vfs_mon_t mon_ff;
    logic     err_done;
    logic     hold_done;
    logic     flash_cat_ff;

    vfs_delay_timer u_err_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (err_any && mon_ff != MON_LATCH),
        .limit   (ctrl_ff.monitor_active ? ACT_DLY : PAS_DLY),
        .done    (err_done)
    );

    vfs_delay_timer u_hold_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (mon_ff == MON_PFAULT),
        .limit   (HOLD_MIN),
        .done    (hold_done)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mon_ff <= MON_OK;
        end else begin
            case (mon_ff)
                MON_OK: begin
                    if (err_done && ctrl_ff.monitor_active) begin
                        mon_ff <= MON_LATCH;
                    end else if (err_done) begin
                        mon_ff <= MON_PFAULT;
                    end
                end
                MON_PFAULT: begin
                    if (err_done && ctrl_ff.monitor_active) begin
                        mon_ff <= MON_LATCH;
                    end else if (hold_done && !err_any) begin
                        mon_ff <= MON_OK;
                    end
                end
                MON_LATCH: begin
                    mon_ff <= MON_LATCH;
                end
                default: begin
                    mon_ff <= MON_OK;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_cat_ff <= 1'b0;
        end else if (mon_ff == MON_OK && err_done) begin
            flash_cat_ff <= sp_err && !s_xdcr && !loop_err;
        end
    end

    logic fault;
    assign fault = (mon_ff != MON_OK);

    // ------------------------------------------------------------------
    // neutral-band solenoid disable
    // ------------------------------------------------------------------
    logic in_band;
    logic enter_done;
    logic exit_done;
    assign in_band = ctrl_ff.neutral_disable_option
                  && sp_eff >= SP_BAND_LO_PM && sp_eff <= SP_BAND_HI_PM;

    vfs_delay_timer u_enter_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (in_band && !neut_passive_ff),
        .limit   (NEUT_ENTER),
        .done    (enter_done)
    );

    vfs_delay_timer u_exit_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (!in_band && neut_passive_ff),
        .limit   (NEUT_EXIT),
        .done    (exit_done)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            neut_passive_ff <= 1'b0;
        end else if (enter_done) begin
            neut_passive_ff <= 1'b1;
        end else if (exit_done) begin
            neut_passive_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // solenoid drive and status
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sol_en_ff       <= 1'b0;
            solenoid_status <= 1'b0;
            loop_active     <= 1'b0;
        end else begin
            sol_en_ff <= !supply_trip && !clock_trip
                      && mon_ff != MON_LATCH && !neut_passive_ff;
            solenoid_status <= ctrl_ff.neutral_disable_option
                            && !ctrl_ff.float_six_pin
                            && !supply_trip && !clock_trip
                            && mon_ff != MON_LATCH && !neut_passive_ff;
            loop_active <= !neut_passive_ff && mon_ff != MON_LATCH;
        end
    end
    assign solenoid_enable = sol_en_ff;

    // ------------------------------------------------------------------
    // direction indication
    // ------------------------------------------------------------------
    logic        a_neutral;
    logic        b_neutral;
    logic [15:0] mag_a;
    logic [15:0] mag_b;
    assign mag_a = s_travel[15] ? 16'(-s_travel) : 16'h0000;
    assign mag_b = s_travel[15] ? 16'h0000 : s_travel;

    vfs_dir_hyst u_dir_a (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .mag        (mag_a),
        .at_neutral (a_neutral)
    );

    vfs_dir_hyst u_dir_b (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .mag        (mag_b),
        .at_neutral (b_neutral)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dir_flag_port_a <= 1'b0;
            dir_flag_port_b <= 1'b0;
        end else begin
            dir_flag_port_a <= ctrl_ff.direction_flag_option
                            && !fault && a_neutral;
            dir_flag_port_b <= ctrl_ff.direction_flag_option
                            && !fault && b_neutral;
        end
    end

    // ------------------------------------------------------------------
    // fault pin, LED and position feedback
    // ------------------------------------------------------------------
    logic [31:0] flash_cnt_ff;
    logic        flash_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_cnt_ff <= 32'h0000_0000;
            flash_ff     <= 1'b0;
        end else if (flash_cnt_ff >= FLASH_HALF) begin
            flash_cnt_ff <= 32'h0000_0000;
            flash_ff     <= !flash_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
        end
    end

    logic signed [23:0] fb_raw;
    assign fb_raw = FB_NEUT_MV - ((signed'({{8{s_travel[15]}}, s_travel}) * FB_GAIN) >>> 8);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_out            <= 1'b0;
            fault_out_oe         <= 1'b1;
            led_green            <= 1'b0;
            led_red              <= 1'b0;
            position_feedback_mv <= 16'h0000;
        end else begin
            fault_out    <= fault;
            fault_out_oe <= 1'b1;
            led_green    <= !fault;
            led_red      <= fault && (!flash_cat_ff || flash_ff);
            if (!ctrl_ff.position_feedback_option) begin
                position_feedback_mv <= 16'h0000;
            end else if (fb_raw < FB_MIN_MV) begin
                position_feedback_mv <= FB_MIN_MV[15:0];
            end else if (fb_raw > FB_MAX_MV) begin
                position_feedback_mv <= FB_MAX_MV[15:0];
            end else begin
                position_feedback_mv <= fb_raw[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------
    assign status = '{solenoid_on:     sol_en_ff,
                      fault:           fault,
                      latched:         mon_ff == MON_LATCH,
                      setpoint_err:    sp_err,
                      xdcr_err:        s_xdcr,
                      loop_err:        loop_err,
                      supply_trip:     supply_trip,
                      clock_trip:      clock_trip,
                      dir_a:           a_neutral,
                      dir_b:           b_neutral,
                      neutral_passive: neut_passive_ff};
    assign reg_rdata = rdata_ff;
endmodule

// *** core/vfs_pkg.sv ***
// Purpose : shared constants and types for the valve fault supervisor
// Assumes : 50 MHz clock, measured values arrive as binary codes
// Notes   : times are kept in their own unit, cycle counts derive from them
package vfs_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned ACT_DLY_MS     = 500;
    localparam int unsigned PAS_DLY_MS     = 250;
    localparam int unsigned HOLD_MIN_MS    = 100;
    localparam int unsigned NEUT_ENTER_MS  = 875;   // inside the 750..1000 ms window
    localparam int unsigned NEUT_EXIT_MS   = 20;    // under the 50 ms limit
    localparam int unsigned FLASH_HALF_MS  = 250;
    localparam int unsigned ACT_DLY_CYC    = ACT_DLY_MS * (CLK_HZ / 1000);
    localparam int unsigned PAS_DLY_CYC    = PAS_DLY_MS * (CLK_HZ / 1000);
    localparam int unsigned HOLD_MIN_CYC   = HOLD_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned NEUT_ENTER_CYC = NEUT_ENTER_MS * (CLK_HZ / 1000);
    localparam int unsigned NEUT_EXIT_CYC  = NEUT_EXIT_MS * (CLK_HZ / 1000);
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------------
    // thresholds (supply in mV, setpoint in per-mille of supply, travel in um)
    // ------------------------------------------------------------------
    localparam logic [15:0] SUPPLY_HI_MV   = 16'h8CA0;  // 36000 mV
    localparam logic [15:0] SUPPLY_LO_MV   = 16'h2134;  // 8500 mV
    localparam logic [9:0]  SP_MIN_PM      = 10'h096;   // 150
    localparam logic [9:0]  SP_MAX_PM      = 10'h352;   // 850
    localparam logic [9:0]  SP_NEUT_PM     = 10'h1F4;   // 500
    localparam logic [9:0]  SP_BAND_LO_PM  = 10'h1E0;   // 480
    localparam logic [9:0]  SP_BAND_HI_PM  = 10'h208;   // 520
    localparam logic signed [19:0] UM_PER_PM   = 20'sh0001C; // 28 um per per-mille
    localparam logic signed [19:0] LOOP_TOL_UM = 20'sh00348; // 840 um, 12 % of stroke
    localparam logic signed [19:0] NEUT_TOL_UM = 20'sh001F4; // 500 um
    localparam logic [15:0] DIR_OUTER_UM   = 16'h0320;  // 800 um
    localparam logic [15:0] DIR_INNER_UM   = 16'h0190;  // 400 um
    localparam logic signed [23:0] FB_NEUT_MV = 24'sh0009C4; // 2500 mV
    localparam logic signed [23:0] FB_MIN_MV  = 24'sh0001F4; // 500 mV
    localparam logic signed [23:0] FB_MAX_MV  = 24'sh001194; // 4500 mV
    localparam logic signed [23:0] FB_GAIN    = 24'sh000049; // 73/256 mV per um

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL_OFS   = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h4;

    typedef struct packed {
        logic float_six_pin;
        logic neutral_disable_option;
        logic direction_flag_option;
        logic position_feedback_option;
        logic monitor_active;
    } vfs_ctrl_t;

    localparam vfs_ctrl_t CTRL_RST = 5'h0F;

    typedef struct packed {
        logic solenoid_on;
        logic fault;
        logic latched;
        logic setpoint_err;
        logic xdcr_err;
        logic loop_err;
        logic supply_trip;
        logic clock_trip;
        logic dir_a;
        logic dir_b;
        logic neutral_passive;
    } vfs_status_t;

    typedef enum logic [1:0] {
        MON_OK     = 2'b00,
        MON_PFAULT = 2'b01,
        MON_LATCH  = 2'b10
    } vfs_mon_t;

endpackage

// *** core/vfs_delay_timer.sv ***
// Purpose : qualifying-time counter
// Assumes : run is a level on the same clock
// Notes   : count restarts whenever run drops; done saturates while run holds
`timescale 1ns/1ns
module vfs_delay_timer
    import vfs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        run,
    input  wire logic [31:0] limit,
    output logic             done
);
    logic [31:0] cnt_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= 32'h0000_0000;
        end else if (!run) begin
            cnt_ff <= 32'h0000_0000;
        end else if (cnt_ff < limit) begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
        end
    end

    assign done = run && (cnt_ff >= limit);
endmodule

// *** core/vfs_dir_hyst.sv ***
// Purpose : one direction indication flag with travel hysteresis
// Assumes : mag is travel toward this flag's port, zero otherwise
// Notes   : flag is high at neutral
`timescale 1ns/1ns
module vfs_dir_hyst
    import vfs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] mag,
    output logic             at_neutral
);
    logic at_neutral_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            at_neutral_ff <= 1'b1;
        end else if (mag > DIR_OUTER_UM) begin
            at_neutral_ff <= 1'b0;
        end else if (mag < DIR_INNER_UM) begin
            at_neutral_ff <= 1'b1;
        end
    end

    assign at_neutral = at_neutral_ff;
endmodule

// *** dv/vfs_supervisor_chk.sv ***
// Purpose : port assertions for the valve fault supervisor
// Assumes : one clock domain
// Notes   : six samples cover the input sync plus the output register
`timescale 1ns/1ns
module vfs_supervisor_chk
    import vfs_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [15:0] main_supply_mv,
    input wire logic [15:0] spool_travel_um,
    input wire logic        clock_fail,
    input wire logic        solenoid_enable,
    input wire logic        fault_out,
    input wire logic        fault_out_oe,
    input wire logic        dir_flag_port_a,
    input wire logic        dir_flag_port_b,
    input wire logic [15:0] position_feedback_mv,
    input wire logic        led_green
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_pin_driven: assert property (fault_out_oe)
        else $error("fault pin released");
    a_hi_trip: assert property ((main_supply_mv > SUPPLY_HI_MV) [*6] |-> !solenoid_enable)
        else $error("solenoids on above supply limit");
    a_lo_trip: assert property ((main_supply_mv < SUPPLY_LO_MV) [*6] |-> !solenoid_enable)
        else $error("solenoids on below supply limit");
    a_clk_trip: assert property (clock_fail [*6] |-> !solenoid_enable)
        else $error("solenoids on with failed clock");
    a_dir_fault: assert property (fault_out [*2] |-> !dir_flag_port_a && !dir_flag_port_b)
        else $error("direction flag high during fault");
    a_fb_centre: assert property ((spool_travel_um == 16'h0000) [*6]
        |-> position_feedback_mv inside {16'h0000, 16'h09C4})
        else $error("feedback not centred at neutral");
    a_dir_a_low: assert property
        (($signed(spool_travel_um) < -$signed(DIR_OUTER_UM)) [*6] |-> !dir_flag_port_a)
        else $error("flag a high beyond outer travel");
    a_dir_b_low: assert property
        (($signed(spool_travel_um) > $signed(DIR_OUTER_UM)) [*6] |-> !dir_flag_port_b)
        else $error("flag b high beyond outer travel");
    a_led_fault: assert property (fault_out [*2] |-> !led_green)
        else $error("green light during fault");
endmodule

bind vfs_supervisor vfs_supervisor_chk u_chk (.*);

// *** dv/vfs_ctrl_model.sv ***
// Purpose : main controller reading fault and direction pins
// Assumes : controller input has a pull-up
// Notes   : a released pin would read as a fault, so quiet must be driven low
`timescale 1ns/1ns
module vfs_ctrl_model (
    input  wire logic clk,
    input  wire logic fault_out,
    input  wire logic fault_out_oe,
    input  wire logic dir_a,
    input  wire logic dir_b,
    output logic      fault_line,
    output logic      hyd_off_ff
);
    assign fault_line = fault_out_oe ? fault_out : 1'b1;
    // hydraulics dumped on fault or when both flags drop
    always_ff @(posedge clk) begin
        hyd_off_ff <= fault_line | (~dir_a & ~dir_b);
    end
endmodule

// *** dv/test_vfs_supervisor.sv ***
// Purpose : self-checking bench for the valve fault supervisor
// Assumes : shortened delays, control register reset enables all options except float_six_pin
// Notes   : long windows are counted in cycles, never waited blindly
`timescale 1ns/1ns
module test_vfs_supervisor
    import vfs_pkg::*;
;
    typedef struct packed {
        logic [15:0] sup;
        logic [9:0]  sp;
        logic [15:0] trv;
        logic        cf;
        logic [2:0]  exp;
    } vfs_row_t;
    // ------------------------------
    // rows: supply, setpoint, travel, clock fail, {enable, flag a, flag b}
    // ------------------------------
    vfs_row_t    rows [12] = '{
        '{16'h5DC0, 10'h1F4, 16'h0000, 1'b0, 3'h7}, '{16'h5DC0, 10'h1CC, 16'hFC18, 1'b0, 3'h5},
        '{16'h5DC0, 10'h1CC, 16'hFDA8, 1'b0, 3'h5}, '{16'h5DC0, 10'h1CC, 16'hFED4, 1'b0, 3'h7},
        '{16'h5DC0, 10'h21C, 16'h03E8, 1'b0, 3'h6}, '{16'h5DC0, 10'h21C, 16'h0000, 1'b0, 3'h7},
        '{16'h8CA0, 10'h1F4, 16'h0000, 1'b0, 3'h7}, '{16'h8CA1, 10'h1F4, 16'h0000, 1'b0, 3'h3},
        '{16'h2134, 10'h1F4, 16'h0000, 1'b0, 3'h7}, '{16'h2133, 10'h1F4, 16'h0000, 1'b0, 3'h3},
        '{16'h5DC0, 10'h1F4, 16'h0000, 1'b1, 3'h3}, '{16'h5DC0, 10'h1CC, 16'h0000, 1'b0, 3'h7}};
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] sup = 16'h5DC0;
    logic [9:0]  sp = 10'h1CC;
    logic [15:0] trv = 16'h0000;
    logic        sol_on = 1'b1;
    logic        cf = 1'b0;
    logic        xf = 1'b0;
    logic        en, lp, flt, oe, da, db, ss, lg, lr, fline, hoff;
    logic [15:0] fb;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          n;
    always #10 clk = ~clk;
    vfs_supervisor #(.ACT_DLY(32'h32), .PAS_DLY(32'h19), .HOLD_MIN(32'hA),
        .NEUT_ENTER(32'h50), .NEUT_EXIT(32'h5)) uut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_supply_mv(sup),
        .control_setpoint(sp), .spool_travel_um(trv), .solenoid_supply_on(sol_on),
        .clock_fail(cf), .xdcr_fault(xf), .solenoid_enable(en), .loop_active(lp),
        .fault_out(flt), .fault_out_oe(oe), .dir_flag_port_a(da), .dir_flag_port_b(db),
        .position_feedback_mv(fb), .solenoid_status(ss), .led_green(lg), .led_red(lr));
    vfs_ctrl_model u_ctrl (.clk(clk), .fault_out(flt), .fault_out_oe(oe), .dir_a(da),
        .dir_b(db), .fault_line(fline), .hyd_off_ff(hoff));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // count edges while a level holds; the bound keeps a stuck output from hanging
    task automatic wait_while(input logic on_flt, input logic v);
        n = 0;
        while ((on_flt ? flt : ss) === v && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        cyc(3000);
        error_cnt++;
        complete_run();
    end
    initial begin
        cyc(6);
        sys_rst <= 1'b0;
        rd(REG_CTRL_OFS, 32'h0000000F);
        rd(4'h8, 32'h0);
        foreach (rows[i]) begin
            @(posedge clk);
            sup <= rows[i].sup;
            sp <= rows[i].sp;
            trv <= rows[i].trv;
            cf <= rows[i].cf;
            cyc(8);
            #1 chk(32'({en, da, db}), 32'(rows[i].exp));
            chk(32'(fline), 32'h0);
            if (rows[i].trv == 16'h0000) chk(32'(fb), 32'h09C4);
            else chk(32'(rows[i].trv[15] ? fb > 16'h09C4 : fb < 16'h09C4), 32'h1);
        end
        $display("table done");
        chk(32'(ss), 32'h1);
        @(posedge clk);
        sp <= SP_NEUT_PM;
        wait_while(1'b0, 1'b1);
        chk(32'(n >= 80 && n <= 90), 32'h1);
        #1 chk(32'({en, lp, ss, flt}), 32'h0);
        @(posedge clk);
        sp <= 10'h1CC;
        wait_while(1'b0, 1'b0);
        chk(32'(n <= 11 && en === 1'b1), 32'h1);
        $display("neutral done");
        sol_on <= 1'b0;
        sp <= 10'h064;
        cyc(70);
        chk(32'(flt), 32'h0);
        sol_on <= 1'b1;
        wait_while(1'b1, 1'b0);
        chk(32'(n >= 50 && n <= 60), 32'h1);
        cyc(2);
        sp <= 10'h1CC;
        cyc(20);
        #1 chk(32'({flt, en, da, db, lg, hoff}), 32'h21);
        $display("active fault done");
        @(posedge clk);
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        wr(REG_CTRL_OFS, 32'h0000000E);
        rd(REG_CTRL_OFS, 32'h0000000E);
        @(posedge clk);
        xf <= 1'b1;
        wait_while(1'b1, 1'b0);
        chk(32'(n >= 25 && n <= 35), 32'h1);
        xf <= 1'b0;
        #1 chk(32'({en, lr, lg}), 32'h6);
        wait_while(1'b1, 1'b1);
        chk(32'(n >= 8 && n <= 20), 32'h1);
        $display("passive fault done");
        trv <= 16'hF830;
        wait_while(1'b1, 1'b0);
        chk(32'(n >= 25 && n <= 35), 32'h1);
        $display("loop fault done");
        wr(REG_CTRL_OFS, 32'h0000001E);
        cyc(2);
        #1 chk(32'(ss), 32'h0);
        $display("float option done");
        complete_run();
    end
endmodule
